// *** src/lhi_pkg.sv ***
// shared types and constants of the lcd host interface front end
package lhi_pkg;

  // host link style picked by the straps
  typedef enum logic [1:0] {LHI_BUS68, LHI_BUS80, LHI_SERIAL, LHI_INVALID} lhi_link_type;
  // parallel width family
  typedef enum logic [1:0] {LHI_W8, LHI_W9, LHI_W16, LHI_W18} lhi_width_type;
  // pixel input width
  typedef enum logic [1:0] {LHI_RGB6, LHI_RGB16, LHI_RGB18} lhi_rgb_type;

  // strap field positions
  localparam int LHI_STRAP_FAMILY_BIT = 3;
  localparam int LHI_STRAP_SERIAL_BIT = 2;
  localparam int LHI_STRAP_STYLE_BIT = 1;
  localparam int LHI_STRAP_NARROW_BIT = 0;
  localparam logic [2:0] LHI_STRAP_SERIAL_CODE = 3'h2;
  localparam logic [1:0] LHI_STRAP_SETTLE = 2'h3;

  // lanes each width drives on reads
  localparam logic [17:0] LHI_MASK_W8 = 18'h3fc00;
  localparam logic [17:0] LHI_MASK_W9 = 18'h3fe00;
  localparam logic [17:0] LHI_MASK_W16 = 18'h3fdfe;
  localparam logic [17:0] LHI_MASK_W18 = 18'h3ffff;
  localparam logic [17:0] LHI_LANES_OFF = 18'h3ffff;

  // serial frame layout
  localparam logic [4:0] LHI_SPI_PREFIX = 5'h0e;
  localparam logic [4:0] LHI_SPI_START_LAST = 5'h07;
  localparam logic [4:0] LHI_SPI_WORD_LAST = 5'h17;
  localparam logic [4:0] LHI_SPI_WORD_FIRST = 5'h08;

  // rgb six bit mode collects three lane groups per pixel
  localparam logic [1:0] LHI_RGB6_LAST = 2'h2;

  // internal oscillator stand-in divides the system clock
  localparam logic [3:0] LHI_OSC_DIV_LAST = 4'h7;

  // pixel buffer shape
  localparam int LHI_FIFO_WIDTH = 20;
  localparam int LHI_FIFO_DEPTH = 32;

  // synchronised pins
  typedef struct packed {
    logic [3:0] straps;
    logic cs_n;
    logic rs;
    logic wrb;
    logic rdb;
    logic sdi;
    logic vs;
    logic hs;
    logic pclk;
    logic de;
    logic eclk_sel;
    logic eclk;
    logic [17:0] data;
  } lhi_pins_type;

  // one decoded host write
  typedef struct packed {
    logic is_data;
    logic [17:0] word;
  } lhi_cmd_type;

  // one buffered pixel with its boundary marks
  typedef struct packed {
    logic frame_first;
    logic line_first;
    logic [17:0] data;
  } lhi_pixel_type;

endpackage

// *** src/lhi_front_end.sv ***
// pixel fifo and the host interface front end of the display driver
//
// Contract
// - straps pick 68 or 80 bus, width family, and narrow width
// - strap code 010 selects serial; other unused codes are invalid
// - in serial mode lowest strap is the identity bit of start byte
// - active low reset initialises the whole block
// - host cycles count only while chip select is low
// - select low: index write or status read; high: data path
// - 68 style: direction pin picks read or write, enable qualifies
// - 80 style: low write strobe pulse performs a write
// - 80 style: low read strobe makes the device drive read data
// - serial mode: write strobe pin is the host serial clock
// - serial input bit sampled on each serial clock rising edge
// - serial output bit changes on serial clock rising edges
// - host lanes: 8 top eight, 9 top nine, 16 skips 9 and 0
// - pixel lanes: 6 top six, 16 skips 12 and 0, 18 all
// - vertical sync marks frame boundaries of pixel input
// - horizontal sync marks line boundaries of pixel input
// - pixel data taken on the host dot clock
// - data enable low marks valid pixels; polarity bit inverts this
// - device drives a frame head pulse for host write pacing
// - external clock select runs the core from the external clock
// - index then data works the same over every host link
// - memory reads go through a read buffer; first read is stale
// - serial start byte read/write and select bits choose the access

// synchronous fifo with a registered output stage
module lhi_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic in_ready;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } lhi_fifo_state_type;

  lhi_fifo_state_type s_reg;
  lhi_fifo_state_type s_next;
  logic take;
  logic load;

  // write, prefetch into the output stage, and full tracking
  always_comb begin
    s_next = s_reg;
    take = in_valid_in && s_reg.in_ready;
    load = (!s_reg.out_valid || out_ready_in) && (s_reg.count != '0);
    if (take) begin
      s_next.mem[s_reg.wr_ptr] = in_data_in;
      s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
    end
    if (load) begin
      s_next.out_data = s_reg.mem[s_reg.rd_ptr];
      s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
      s_next.out_valid = 1'b1;
    end else if (out_ready_in) begin
      s_next.out_valid = 1'b0;
    end
    s_next.count = s_reg.count + {{AW{1'b0}}, take} - {{AW{1'b0}}, load};
    s_next.in_ready = (s_next.count != (AW+1)'(DEPTH));
  end

  // state register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_reg <= '0;
      s_reg.in_ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign in_ready_out = s_reg.in_ready;
  assign out_valid_out = s_reg.out_valid;
  assign out_data_out = s_reg.out_data;
endmodule

// host link decoder, read buffer, serial engine and pixel intake
module lhi_front_end
  import lhi_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] interface_select_straps_in,
  input wire logic chip_select_n_in,
  input wire logic register_select_in,
  input wire logic dir_or_write_strobe_in,
  input wire logic enable_or_read_strobe_in,
  input wire logic serial_data_in,
  input wire logic [17:0] host_data_lanes_in,
  input wire logic vsync_in,
  input wire logic hsync_in,
  input wire logic pixel_clock_in,
  input wire logic data_enable_in,
  input wire logic ext_clock_select_in,
  input wire logic ext_clock_in,
  input wire logic rgb_enable_in,
  input wire lhi_rgb_type rgb_width_in,
  input wire logic enable_polarity_bit_in,
  input wire logic [8:0] status_line_in,
  input wire logic [17:0] mem_data_in,
  input wire logic scan_frame_start_in,
  input wire logic pixel_ready_in,
  output logic [17:0] host_data_lanes_out,
  output logic [17:0] host_data_lanes_oe_n_out,
  output logic serial_data_out,
  output lhi_link_type link_mode_out,
  output lhi_width_type link_width_out,
  output logic [7:0] index_register_out,
  output logic cmd_valid_out,
  output lhi_cmd_type cmd_out,
  output logic mem_read_req_out,
  output logic pixel_valid_out,
  output lhi_pixel_type pixel_out,
  output logic pixel_overflow_out,
  output logic frame_head_pulse_out,
  output logic core_tick_out,
  output logic ext_clock_active_out
);

  typedef struct packed {
    lhi_pins_type sync1;
    lhi_pins_type sync2;
    lhi_pins_type prev;
    logic [1:0] strap_wait;
    logic strap_done;
    lhi_link_type link;
    lhi_width_type width;
    logic id_bit;
    logic wr_half;
    logic rd_half;
    logic [17:0] wr_acc;
    logic [7:0] index;
    logic cmd_valid;
    lhi_cmd_type cmd;
    logic [17:0] read_buffer;
    logic mem_rd_req;
    logic [17:0] dq_out;
    logic [17:0] dq_oe_n;
    logic [4:0] spi_cnt;
    logic [15:0] spi_in;
    logic [15:0] spi_out;
    logic spi_ok;
    logic spi_rw;
    logic spi_rs;
    logic sdo;
    logic [1:0] pix_part;
    logic [17:0] pix_acc;
    logic frame_flag;
    logic line_flag;
    logic push;
    lhi_pixel_type push_word;
    logic overflow;
    logic [3:0] osc_cnt;
    logic tick;
    logic ext_active;
    logic frame_head_pulse;
  } lhi_state_type;

  lhi_state_type s_reg;
  lhi_state_type s_next;
  lhi_pins_type pins;
  lhi_pins_type p;
  lhi_pins_type q;
  logic fifo_ready;
  logic sel;
  logic narrow;
  logic wr_end;
  logic rd_start;
  logic rd_end;
  logic sclk_rise;
  logic pclk_rise;
  logic pix_valid;
  logic [7:0] start_byte;
  logic [17:0] word;
  logic [17:0] rd_word;

  // merge one host transfer into the word under assembly
  function automatic logic [17:0] lhi_from_lanes(lhi_width_type w, logic [17:0] l,
                                                 logic first, logic [17:0] acc);
    unique case (w)
      LHI_W8: lhi_from_lanes = first ? {2'h0, l[17:10], 8'h00} : {acc[17:8], l[17:10]};
      LHI_W9: lhi_from_lanes = first ? {l[17:9], 9'h000} : {acc[17:9], l[17:9]};
      LHI_W16: lhi_from_lanes = {2'h0, l[17:10], l[8:1]};
      LHI_W18: lhi_from_lanes = l;
    endcase
  endfunction

  // place one part of a word onto the lanes of the width
  function automatic logic [17:0] lhi_to_lanes(lhi_width_type w, logic [17:0] d, logic first);
    unique case (w)
      LHI_W8: lhi_to_lanes = {first ? d[15:8] : d[7:0], 10'h000};
      LHI_W9: lhi_to_lanes = {first ? d[17:9] : d[8:0], 9'h000};
      LHI_W16: lhi_to_lanes = {d[15:8], 1'b0, d[7:0], 1'b0};
      LHI_W18: lhi_to_lanes = d;
    endcase
  endfunction

  // lanes that a width may drive, as active low enables
  function automatic logic [17:0] lhi_oe_n(lhi_width_type w);
    unique case (w)
      LHI_W8: lhi_oe_n = ~LHI_MASK_W8;
      LHI_W9: lhi_oe_n = ~LHI_MASK_W9;
      LHI_W16: lhi_oe_n = ~LHI_MASK_W16;
      LHI_W18: lhi_oe_n = ~LHI_MASK_W18;
    endcase
  endfunction

  // pixel data buffer toward the timing controller
  lhi_fifo #(
    .WIDTH(LHI_FIFO_WIDTH),
    .DEPTH(LHI_FIFO_DEPTH)
  ) u_pixel_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(s_reg.push),
    .in_data_in(s_reg.push_word),
    .in_ready_out(fifo_ready),
    .out_valid_out(pixel_valid_out),
    .out_data_out(pixel_out),
    .out_ready_in(pixel_ready_in)
  );

  // gather the asynchronous pins
  always_comb begin
    pins.straps = interface_select_straps_in;
    pins.cs_n = chip_select_n_in;
    pins.rs = register_select_in;
    pins.wrb = dir_or_write_strobe_in;
    pins.rdb = enable_or_read_strobe_in;
    pins.sdi = serial_data_in;
    pins.vs = vsync_in;
    pins.hs = hsync_in;
    pins.pclk = pixel_clock_in;
    pins.de = data_enable_in;
    pins.eclk_sel = ext_clock_select_in;
    pins.eclk = ext_clock_in;
    pins.data = host_data_lanes_in;
  end

  // next state of the whole front end
  always_comb begin
    s_next = s_reg;
    p = s_reg.sync2;
    q = s_reg.prev;
    s_next.sync1 = pins;
    s_next.sync2 = s_reg.sync1;
    s_next.prev = s_reg.sync2;
    s_next.cmd_valid = 1'b0;
    s_next.mem_rd_req = 1'b0;
    s_next.push = 1'b0;
    s_next.frame_head_pulse = scan_frame_start_in;
    narrow = (s_reg.width == LHI_W8) || (s_reg.width == LHI_W9);
    sel = !p.cs_n;
    word = '0;
    start_byte = '0;

    // straps are caught once the synchronisers have settled after reset
    if (!s_reg.strap_done) begin
      s_next.strap_wait = s_reg.strap_wait + 2'h1;
      if (s_reg.strap_wait == LHI_STRAP_SETTLE) begin
        s_next.strap_done = 1'b1;
        s_next.id_bit = p.straps[LHI_STRAP_NARROW_BIT];
        if (p.straps[3:1] == LHI_STRAP_SERIAL_CODE) begin
          s_next.link = LHI_SERIAL;
        end else if (p.straps[LHI_STRAP_SERIAL_BIT]) begin
          s_next.link = LHI_INVALID;
        end else begin
          s_next.link = p.straps[LHI_STRAP_STYLE_BIT] ? LHI_BUS80 : LHI_BUS68;
        end
        unique case ({p.straps[LHI_STRAP_FAMILY_BIT], p.straps[LHI_STRAP_NARROW_BIT]})
          2'h0: s_next.width = LHI_W16;
          2'h1: s_next.width = LHI_W8;
          2'h2: s_next.width = LHI_W18;
          2'h3: s_next.width = LHI_W9;
        endcase
      end
    end

    // strobe decoding per bus style
    if (s_reg.link == LHI_BUS80) begin
      wr_end = sel && !q.wrb && p.wrb;
      rd_start = sel && q.rdb && !p.rdb;
      rd_end = !q.rdb && p.rdb;
    end else if (s_reg.link == LHI_BUS68) begin
      wr_end = sel && q.rdb && !p.rdb && !q.wrb;
      rd_start = sel && !q.rdb && p.rdb && p.wrb;
      rd_end = q.rdb && !p.rdb;
    end else begin
      wr_end = 1'b0;
      rd_start = 1'b0;
      rd_end = 1'b0;
    end
    rd_word = q.rs ? s_reg.read_buffer : {9'h000, status_line_in};
    if (s_reg.link == LHI_BUS80 || s_reg.link == LHI_BUS68) begin
      rd_word = p.rs ? s_reg.read_buffer : {9'h000, status_line_in};
    end

    // parallel write: lanes of the width only, two parts when narrow
    if (wr_end) begin
      word = lhi_from_lanes(s_reg.width, q.data, !s_reg.wr_half, s_reg.wr_acc);
      if (narrow && !s_reg.wr_half) begin
        s_next.wr_acc = word;
        s_next.wr_half = 1'b1;
      end else begin
        s_next.wr_half = 1'b0;
        s_next.cmd_valid = 1'b1;
        s_next.cmd.is_data = q.rs;
        s_next.cmd.word = word;
        if (!q.rs) begin
          s_next.index = word[7:0];
        end
      end
    end

    // parallel read: drive used lanes, reload the read buffer at the end
    if (rd_start) begin
      s_next.dq_out = lhi_to_lanes(s_reg.width, rd_word, !s_reg.rd_half);
      s_next.dq_oe_n = lhi_oe_n(s_reg.width);
    end
    if (rd_end && !s_reg.dq_oe_n[17]) begin
      s_next.dq_oe_n = LHI_LANES_OFF;
      if (narrow && !s_reg.rd_half) begin
        s_next.rd_half = 1'b1;
      end else begin
        s_next.rd_half = 1'b0;
        if (q.rs) begin
          s_next.read_buffer = mem_data_in;
          s_next.mem_rd_req = 1'b1;
        end
      end
    end

    // serial engine on the write strobe pin used as clock
    sclk_rise = (s_reg.link == LHI_SERIAL) && sel && !q.wrb && p.wrb;
    if (sclk_rise) begin
      s_next.spi_in = {s_reg.spi_in[14:0], p.sdi};
      s_next.spi_cnt = s_reg.spi_cnt + 5'h01;
      s_next.sdo = s_reg.spi_out[15];
      s_next.spi_out = {s_reg.spi_out[14:0], 1'b0};
      if (s_reg.spi_cnt == LHI_SPI_START_LAST) begin
        start_byte = {s_reg.spi_in[6:0], p.sdi};
        s_next.spi_ok = (start_byte[7:3] == LHI_SPI_PREFIX) && (start_byte[2] == s_reg.id_bit);
        s_next.spi_rs = start_byte[1];
        s_next.spi_rw = start_byte[0];
        s_next.spi_out = start_byte[1] ? s_reg.read_buffer[15:0] : {7'h00, status_line_in};
      end
      if (s_reg.spi_cnt == LHI_SPI_WORD_LAST) begin
        s_next.spi_cnt = LHI_SPI_WORD_FIRST;
        if (s_reg.spi_ok && !s_reg.spi_rw) begin
          s_next.cmd_valid = 1'b1;
          s_next.cmd.is_data = s_reg.spi_rs;
          s_next.cmd.word = {2'h0, s_reg.spi_in[14:0], p.sdi};
          if (!s_reg.spi_rs) begin
            s_next.index = {s_reg.spi_in[6:0], p.sdi};
          end
        end
        if (s_reg.spi_ok && s_reg.spi_rw && s_reg.spi_rs) begin
          s_next.read_buffer = mem_data_in;
          s_next.mem_rd_req = 1'b1;
          s_next.spi_out = mem_data_in[15:0];
        end
      end
    end

    // deselect ends any cycle in progress and floats the lanes
    if (p.cs_n) begin
      s_next.dq_oe_n = LHI_LANES_OFF;
      s_next.wr_half = 1'b0;
      s_next.rd_half = 1'b0;
      s_next.spi_cnt = '0;
      s_next.spi_ok = 1'b0;
      s_next.sdo = 1'b0;
    end

    // pixel intake on the dot clock
    pclk_rise = rgb_enable_in && !q.pclk && p.pclk;
    pix_valid = (p.de == enable_polarity_bit_in);
    if (s_reg.push) begin
      s_next.frame_flag = 1'b0;
      s_next.line_flag = 1'b0;
    end
    if (rgb_enable_in && q.vs && !p.vs) begin
      s_next.frame_flag = 1'b1;
    end
    if (rgb_enable_in && q.hs && !p.hs) begin
      s_next.line_flag = 1'b1;
    end
    if (pclk_rise && pix_valid) begin
      word = '0;
      unique case (rgb_width_in)
        LHI_RGB6: word = {s_reg.pix_acc[11:0], p.data[17:12]};
        LHI_RGB16: word = {2'h0, p.data[17:13], p.data[11:1]};
        LHI_RGB18: word = p.data;
        default: word = p.data;
      endcase
      s_next.pix_acc = word;
      s_next.pix_part = '0;
      if (rgb_width_in == LHI_RGB6 && s_reg.pix_part != LHI_RGB6_LAST) begin
        s_next.pix_part = s_reg.pix_part + 2'h1;
      end else if (fifo_ready) begin
        s_next.push = 1'b1;
        s_next.push_word.frame_first = s_next.frame_flag;
        s_next.push_word.line_first = s_next.line_flag;
        s_next.push_word.data = word;
      end else begin
        s_next.overflow = 1'b1;
      end
    end

    // core tick from the internal divider or the external clock
    s_next.ext_active = p.eclk_sel;
    s_next.osc_cnt = (s_reg.osc_cnt == LHI_OSC_DIV_LAST) ? '0 : s_reg.osc_cnt + 4'h1;
    s_next.tick = p.eclk_sel ? (!q.eclk && p.eclk) : (s_reg.osc_cnt == LHI_OSC_DIV_LAST);
  end

  // state register; everything returns to its idle value under reset
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_reg <= '0;
      s_reg.link <= LHI_INVALID;
      s_reg.dq_oe_n <= LHI_LANES_OFF;
    end else begin
      s_reg <= s_next;
    end
  end

  assign host_data_lanes_out = s_reg.dq_out;
  assign host_data_lanes_oe_n_out = s_reg.dq_oe_n;
  assign serial_data_out = s_reg.sdo;
  assign link_mode_out = s_reg.link;
  assign link_width_out = s_reg.width;
  assign index_register_out = s_reg.index;
  assign cmd_valid_out = s_reg.cmd_valid;
  assign cmd_out = s_reg.cmd;
  assign mem_read_req_out = s_reg.mem_rd_req;
  assign pixel_overflow_out = s_reg.overflow;
  assign frame_head_pulse_out = s_reg.frame_head_pulse;
  assign core_tick_out = s_reg.tick;
  assign ext_clock_active_out = s_reg.ext_active;
endmodule

// *** tb/lhi_front_end_sva.sv ***
// assertions watching the host interface front end ports
module lhi_front_end_sva
  import lhi_pkg::*;
(
  input logic clk_in,
  input logic reset_n_in,
  input logic [3:0] interface_select_straps_in,
  input logic chip_select_n_in,
  input logic enable_or_read_strobe_in,
  input logic ext_clock_select_in,
  input logic scan_frame_start_in,
  input logic pixel_ready_in,
  input logic [17:0] host_data_lanes_oe_n_out,
  input lhi_link_type link_mode_out,
  input lhi_width_type link_width_out,
  input logic cmd_valid_out,
  input logic pixel_valid_out,
  input lhi_pixel_type pixel_out,
  input logic pixel_overflow_out,
  input logic frame_head_pulse_out,
  input logic ext_clock_active_out
);
  logic [3:0] up_reg;
  logic [3:0] s;
  lhi_link_type mode_exp;
  logic [17:0] lane_mask;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  // saturating cycles since reset
  assign s = interface_select_straps_in;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) up_reg <= 4'h0;
    else up_reg <= up_reg + {3'h0, ~&up_reg};
  end

  // expected link style and lane mask
  always_comb begin
    if (s[3:1] == 3'h2) mode_exp = LHI_SERIAL;
    else if (s[2]) mode_exp = LHI_INVALID;
    else if (s[1]) mode_exp = LHI_BUS80;
    else mode_exp = LHI_BUS68;
    case (link_width_out)
      LHI_W8: lane_mask = LHI_MASK_W8;
      LHI_W9: lane_mask = LHI_MASK_W9;
      LHI_W16: lane_mask = LHI_MASK_W16;
      default: lane_mask = LHI_MASK_W18;
    endcase
  end

  mode_decode_a: assert property (up_reg >= 4'h8 |-> link_mode_out == mode_exp)
    else $error("bad mode");
  width_decode_a: assert property (up_reg >= 4'h8 && !link_mode_out[1] |-> link_width_out == {~s[0], s[3]})
    else $error("bad width");
  cmd_pulse_a: assert property (cmd_valid_out |=> !cmd_valid_out)
    else $error("long cmd pulse");
  deselect_quiet_a: assert property (chip_select_n_in [*6] |-> !cmd_valid_out)
    else $error("cmd deselected");
  lanes_float_a: assert property (chip_select_n_in [*6] |-> &host_data_lanes_oe_n_out)
    else $error("lanes driven");
  unused_lanes_a: assert property ((~host_data_lanes_oe_n_out & ~lane_mask) == 18'h0)
    else $error("unused lane driven");
  read_drive_a: assert property ((link_mode_out == LHI_BUS80 && !chip_select_n_in && !enable_or_read_strobe_in) [*6]
    |-> ~&host_data_lanes_oe_n_out)
    else $error("read not driven");
  read_release_a: assert property ($rose(enable_or_read_strobe_in) && link_mode_out == LHI_BUS80
    |-> ##[1:6] &host_data_lanes_oe_n_out)
    else $error("lanes not released");
  ext_select_a: assert property (ext_clock_select_in [*5] |-> ext_clock_active_out)
    else $error("ext select ignored");
  frame_head_a: assert property (frame_head_pulse_out == $past(scan_frame_start_in))
    else $error("frame head late");
  pixel_hold_a: assert property (pixel_valid_out && !pixel_ready_in |=> pixel_valid_out && $stable(pixel_out))
    else $error("pixel not held");

  cmd_seen_c: cover property (cmd_valid_out);
  serial_cmd_c: cover property (link_mode_out == LHI_SERIAL && cmd_valid_out);
  overflow_c: cover property (pixel_overflow_out);
endmodule

bind lhi_front_end lhi_front_end_sva i_sva (.*);

// *** tb/lhi_host_model.sv ***
// host model driving the front end pins
module lhi_host_model (
  input wire logic clk_in,
  input wire logic [17:0] lanes_in,
  output logic cs_n_out = 1'b1,
  output logic rs_out = 1'b0,
  output logic wr_out = 1'b1,
  output logic rd_out = 1'b1,
  output logic sdi_out = 1'b0,
  output logic [17:0] lanes_out = 18'h0,
  output logic pclk_out = 1'b1,
  output logic de_out = 1'b1,
  output logic sync_out = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;

  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // strobe idle levels
  task automatic idle(input bit s68);
    wr_out <= 1'b1;
    rd_out <= ~s68;
  endtask

  // one write in either bus style
  task automatic wr(input bit s68, input bit cs_n, input bit rs, input logic [17:0] d);
    cs_n_out <= cs_n;
    rs_out <= rs;
    lanes_out <= d;
    wr_out <= 1'b0;
    w(5);
    if (s68) begin
      rd_out <= 1'b1;
      w(5);
      rd_out <= 1'b0;
      w(5);
    end
    wr_out <= 1'b1;
    w(6);
  endtask

  // deselect and disturb the idle lines
  task automatic done();
    cs_n_out <= 1'b1;
    lanes_out <= ~lanes_out;
    sdi_out <= ~sdi_out;
    w(8);
  endtask

  // one read
  task automatic rd(input bit s68, input bit rs, output logic [17:0] q);
    cs_n_out <= 1'b0;
    rs_out <= rs;
    lanes_out <= ~lanes_out;
    rd_out <= s68;
    w(8);
    q = lanes_in;
    rd_out <= ~s68;
    w(6);
  endtask

  // serial write frame, msb first
  task automatic spi(input bit rs, input bit id, input logic [15:0] d);
    logic [23:0] f;
    f = {5'h0e, id, rs, 1'b0, d};
    cs_n_out <= 1'b0;
    wr_out <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi_out <= f[i];
      w(4);
      wr_out <= 1'b1;
      w(4);
      wr_out <= 1'b0;
    end
    w(4);
    done();
  endtask

  // one dot clock period
  task automatic px(input logic [17:0] d, input bit de);
    lanes_out <= d;
    de_out <= de;
    pclk_out <= 1'b0;
    w(4);
    pclk_out <= 1'b1;
    w(4);
  endtask

  // frame and line boundary together
  task automatic sync();
    sync_out <= 1'b0;
    w(4);
    sync_out <= 1'b1;
    w(4);
  endtask
endmodule

// *** tb/tb.sv ***
// testbench of the lcd host interface front end
module tb import lhi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [3:0] st; logic rs; logic [17:0] d0; logic [17:0] d1; logic [17:0] w;} lhi_row_type;
  logic clk_in = 1'b0, reset_n_in = 1'b0, ext_sel = 1'b0, ext_clk = 1'b0, rgb_en = 1'b0, pol = 1'b0;
  logic [3:0] straps = 4'ha;
  logic [8:0] status = 9'h0;
  logic [17:0] mem = 18'h0;
  logic scan = 1'b0, ready = 1'b0;
  logic cs_n, rs, wr, rd, sdi, pclk, de, sync, cmd_valid, mem_req, pix_valid, ovf, tick, fhead;
  logic [17:0] host_lanes, pins, dut_lanes, oe_n, q;
  logic [7:0] idx;
  lhi_cmd_type cmd, got;
  lhi_pixel_type pix, first, last;
  int num_errors = 0;
  int samples_checked = 0;
  int ncmd = 0, nreq = 0, npop = 0, nt = 0, cycles = 0, n = 0;
  lhi_row_type rows [8] = '{
    '{4'ha, 1'b1, 18'h2a5c3, 18'h00000, 18'h2a5c3}, '{4'h2, 1'b0, 18'h2b7a5, 18'h00000, 18'h0add2},
    '{4'h3, 1'b1, 18'h12d55, 18'h1e3ff, 18'h04b78}, '{4'hb, 1'b1, 18'h2b1ff, 18'h0c9ab, 18'h2b064},
    '{4'h8, 1'b0, 18'h000c3, 18'h00000, 18'h000c3}, '{4'h0, 1'b1, 18'h2b7a5, 18'h00000, 18'h0add2},
    '{4'h1, 1'b0, 18'h12d55, 18'h1e3ff, 18'h04b78}, '{4'h9, 1'b1, 18'h2b1ff, 18'h0c9ab, 18'h2b064}};

  initial forever #20 clk_in = ~clk_in;
  // resolved lane levels
  assign pins = (dut_lanes & ~oe_n) | (host_lanes & oe_n);

  lhi_host_model i_host (.clk_in(clk_in), .lanes_in(pins), .cs_n_out(cs_n), .rs_out(rs), .wr_out(wr),
    .rd_out(rd), .sdi_out(sdi), .lanes_out(host_lanes), .pclk_out(pclk), .de_out(de), .sync_out(sync));

  lhi_front_end i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .interface_select_straps_in(straps),
    .chip_select_n_in(cs_n), .register_select_in(rs), .dir_or_write_strobe_in(wr),
    .enable_or_read_strobe_in(rd), .serial_data_in(sdi), .host_data_lanes_in(pins), .vsync_in(sync),
    .hsync_in(sync), .pixel_clock_in(pclk), .data_enable_in(de), .ext_clock_select_in(ext_sel),
    .ext_clock_in(ext_clk), .rgb_enable_in(rgb_en), .rgb_width_in(LHI_RGB18), .enable_polarity_bit_in(pol),
    .status_line_in(status), .mem_data_in(mem), .scan_frame_start_in(scan), .pixel_ready_in(ready),
    .host_data_lanes_out(dut_lanes), .host_data_lanes_oe_n_out(oe_n), .serial_data_out(),
    .link_mode_out(), .link_width_out(), .index_register_out(idx), .cmd_valid_out(cmd_valid), .cmd_out(cmd),
    .mem_read_req_out(mem_req), .pixel_valid_out(pix_valid), .pixel_out(pix), .pixel_overflow_out(ovf),
    .frame_head_pulse_out(fhead), .core_tick_out(tick), .ext_clock_active_out());

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // reset with new straps
  task automatic rst(input logic [3:0] st);
    reset_n_in <= 1'b0;
    straps <= st;
    i_host.idle(~st[1]);
    repeat (2) @(posedge clk_in);
    chk("oe_reset", {2'h0, oe_n}, 20'h3ffff);
    reset_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask

  // event counters and the hang limit
  always @(posedge clk_in) begin
    cycles++;
    if (cmd_valid) got = cmd;
    if (cmd_valid) ncmd++;
    if (mem_req) nreq++;
    if (tick) nt++;
    if (pix_valid && ready) begin
      if (npop == 0) first = pix;
      last = pix;
      npop++;
    end
    if (cycles == 6000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    foreach (rows[i]) begin
      rst(rows[i].st);
      n = ncmd;
      i_host.wr(~rows[i].st[1], 1'b0, rows[i].rs, rows[i].d0);
      if (rows[i].st[0]) i_host.wr(~rows[i].st[1], 1'b0, rows[i].rs, rows[i].d1);
      i_host.done();
      chk("cmd", {1'b0, got}, {1'b0, rows[i].rs, rows[i].w});
      chk("cmd_count", 20'(ncmd - n), 20'h1);
      if (!rows[i].rs) chk("index", {12'h0, idx}, {12'h0, rows[i].w[7:0]});
    end
    rst(4'ha);
    n = ncmd;
    i_host.wr(1'b0, 1'b1, 1'b1, 18'h11111);
    i_host.done();
    chk("deselected", 20'(ncmd - n), 20'h0);
    status <= 9'h1a5;
    mem <= 18'h15a5a;
    i_host.rd(1'b0, 1'b0, q);
    chk("status", {2'h0, q}, 20'h001a5);
    n = nreq;
    i_host.rd(1'b0, 1'b1, q);
    i_host.rd(1'b0, 1'b1, q);
    i_host.done();
    chk("mem_read", {2'h0, q}, 20'h15a5a);
    chk("mem_req", 20'(nreq - n), 20'h2);
    rst(4'h0);
    status <= 9'h0a5;
    i_host.rd(1'b1, 1'b0, q);
    i_host.done();
    chk("status16", {2'h0, q & 18'h3fdfe}, 20'h0014a);
    rst(4'h5);
    i_host.spi(1'b0, 1'b1, 16'h00a7);
    chk("spi_index", {12'h0, idx}, 20'h000a7);
    n = ncmd;
    i_host.spi(1'b1, 1'b0, 16'h1234);
    chk("spi_bad_id", 20'(ncmd - n), 20'h0);
    i_host.spi(1'b1, 1'b1, 16'hbeef);
    chk("spi_data", {1'b0, got}, 20'h4beef);
    rst(4'ha);
    rgb_en <= 1'b1;
    i_host.sync();
    i_host.px(18'h3ffff, 1'b1);
    for (int i = 0; i < 40; i++) i_host.px(18'(i), 1'b0);
    chk("overflow", {19'h0, ovf}, 20'h1);
    ready <= 1'b1;
    repeat (80) @(posedge clk_in);
    chk("first_pixel", first, 20'hc0000);
    chk("pops", 20'(npop >= 32 && npop <= 34), 20'h1);
    n = npop;
    pol <= 1'b1;
    i_host.px(18'h00abc, 1'b1);
    i_host.px(18'h3ffff, 1'b0);
    repeat (20) @(posedge clk_in);
    chk("polarity", {2'h0, last.data}, 20'h00abc);
    chk("pol_count", 20'(npop - n), 20'h1);
    scan <= 1'b1;
    ext_sel <= 1'b1;
    @(posedge clk_in);
    scan <= 1'b0;
    repeat (10) @(posedge clk_in);
    n = nt;
    repeat (5) begin
      ext_clk <= 1'b1;
      repeat (4) @(posedge clk_in);
      ext_clk <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
    repeat (6) @(posedge clk_in);
    chk("ext_ticks", 20'(nt - n), 20'h5);
    close_out();
  end
endmodule
